// File: core/sfr_fifo.v
// Parameterised first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/10ps
`default_nettype none
module sfr_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire nrst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  // Storage array.
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  // Write and read pointers with one wrap bit.
  reg [AW:0] wptr;
  reg [AW:0] rptr;
  wire full;
  wire empty;
  wire push;
  wire pop;

  assign empty = (wptr == rptr);
  assign full = (wptr[AW-1:0] == rptr[AW-1:0]) && (wptr[AW] != rptr[AW]);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign push = in_valid && !full;
  assign pop = out_ready && !empty;
  assign out_data = mem[rptr[AW-1:0]];

  // ***********************************************
  // Pointer update
  // ***********************************************
  // Pointers advance on each accepted push or pop.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr <= {(AW+1){1'b0}};
      rptr <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wptr <= wptr + 1'b1;
      end
      if (pop) begin
        rptr <= rptr + 1'b1;
      end
    end
  end

  // Memory write has no reset so it can map to RAM.
  always @(posedge clk) begin
    if (push) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// File: core/sfr_map.vh
// Constants for the synchronous bit-oriented frame receiver.
`ifndef SFR_MAP_VH
`define SFR_MAP_VH
// Residue of a good frame whose CRC was sent inverted.
`define SFR_GOOD_RESIDUE 16'h1D0F
// Reflected CRC polynomial for the checker.
`define SFR_CRC_POLY 16'h8408
// Preset values of the checker.
`define SFR_PRESET_ONES 16'hFFFF
`define SFR_PRESET_ZERO 16'h0000
// Ones needed for stuffing and for abort.
`define SFR_ONES_STUFF 3'h5
`define SFR_ONES_ABORT 3'h7
// Character length codes.
`define SFR_LEN5 2'h0
`define SFR_LEN6 2'h2
`define SFR_LEN7 2'h1
`define SFR_LEN8 2'h3
// Receive interrupt modes that lock the FIFO after end of frame.
`define SFR_RXI_FIRST 2'h1
`define SFR_RXI_SPECIAL 2'h3
// Width of one FIFO entry: residue (3), crc error, eof, data (8).
`define SFR_ENTRY_W 13
`define SFR_E_EOF 8
`define SFR_E_CRC 9
`define SFR_E_RES_LO 10
`endif

// File: core/sfr_receiver.v
// Bit-oriented synchronous frame receiver with flag hunt, abort and CRC.
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map.vh"
module sfr_receiver #(
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk,
  input wire nrst,
  input wire rx_clk_pin,
  input wire rx_data_pin,
  input wire carrier_detect_pin,
  input wire rx_enable,
  input wire auto_enable,
  input wire enter_hunt,
  input wire [1:0] char_len,
  input wire crc_preset_ones,
  input wire [1:0] rx_int_mode,
  input wire error_reset,
  input wire terminal_ready_bit,
  input wire dma_req_mode,
  input wire dma_req,
  input wire [7:0] flag_pattern_reg,
  input wire rd_data,
  output reg [7:0] rx_data,
  output wire rx_avail,
  output reg end_of_frame,
  output reg crc_error,
  output reg [2:0] residue_code,
  output reg special_condition,
  output reg hunt_state,
  output reg break_abort,
  output reg carrier_detect_bit,
  output reg ext_status_event,
  output reg address_byte,
  output reg sync_n,
  output reg terminal_ready_n
);
  // ***********************************************
  // Input synchronisers
  // ***********************************************
  // Two stages each for link clock, data and carrier pin.
  reg [2:0] sync_a;
  reg [2:0] sync_b;
  reg rxc_prev; // Last synchronised link clock level.
  wire rxc_rise;
  wire rx_bit;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      rxc_prev <= 1'b0;
    end else begin
      sync_a <= {carrier_detect_pin, rx_data_pin, rx_clk_pin};
      sync_b <= sync_a;
      rxc_prev <= sync_b[0];
    end
  end
  assign rxc_rise = sync_b[0] && !rxc_prev;
  assign rx_bit = sync_b[1];

  // Receiver runs when enabled and, under auto-enable, carrier is low.
  wire rx_on = rx_enable && !(auto_enable && sync_b[2]);

  // CRC step on one bit, LSB first.
  function [15:0] crc_step;
    input [15:0] c;
    input b;
    begin
      if (c[0] ^ b) begin
        crc_step = (c >> 1) ^ `SFR_CRC_POLY;
      end else begin
        crc_step = c >> 1;
      end
    end
  endfunction

  // Bits per character from the length code.
  function [3:0] len_bits;
    input [1:0] code;
    begin
      case (code)
        `SFR_LEN5: len_bits = 4'h5;
        `SFR_LEN6: len_bits = 4'h6;
        `SFR_LEN7: len_bits = 4'h7;
        default: len_bits = 4'h8;
      endcase
    end
  endfunction

  // Bit-reverses the checker register, which holds its remainder LSB first.
  function [15:0] bit_rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        bit_rev16[k] = v[15 - k];
      end
    end
  endfunction

  // ***********************************************
  // Bit stream state
  // ***********************************************
  reg [7:0] pat; // Last eight raw bits, newest in bit 7.
  reg [2:0] ones; // Run of consecutive ones.
  reg [7:0] shreg; // Character being assembled.
  reg [3:0] nbits; // Bits in the character so far.
  reg [2:0] since_flag; // Data bits since the flag, modulo eight, residue.
  reg [15:0] crc; // Checker remainder.
  reg in_frame; // Data seen since the opening flag.
  reg first_char; // Next character is the address field.
  reg [7:0] data_mark; // Set where the bit held in pat is a data bit.
  reg [`SFR_ENTRY_W-1:0] push_data;
  reg push;
  reg locked; // FIFO held after end-of-frame.
  wire push_ready;
  wire pop_valid;
  wire [`SFR_ENTRY_W-1:0] pop_data;
  wire [7:0] next_pat = {rx_bit, pat[7:1]};
  wire flag_hit = (next_pat == flag_pattern_reg);
  wire abort_hit = rx_bit && (ones == (`SFR_ONES_ABORT - 3'h1));
  wire stuffed = !rx_bit && (ones == `SFR_ONES_STUFF);
  wire [15:0] preset = crc_preset_ones ? `SFR_PRESET_ONES : `SFR_PRESET_ZERO;
  wire [3:0] want = len_bits(char_len);
  // The bit leaving pat, folded into checker, character and residue.
  wire [15:0] crc_fin = data_mark[0] ? crc_step(crc, pat[0]) : crc;
  wire [7:0] sh_fin = data_mark[0] ? {pat[0], shreg[7:1]} : shreg;
  wire [2:0] res_fin = since_flag + {2'h0, data_mark[0]};
  // A good frame leaves the fixed residue, not zero, in the checker.
  wire crc_bad = (bit_rev16(crc_fin) != `SFR_GOOD_RESIDUE);

  // ***********************************************
  // Receive process
  // ***********************************************
  // Acts once per rising link clock edge while the receiver is on.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pat <= 8'h00;
      ones <= 3'h0;
      shreg <= 8'h00;
      nbits <= 4'h0;
      since_flag <= 3'h0;
      crc <= `SFR_PRESET_ZERO;
      in_frame <= 1'b0;
      first_char <= 1'b0;
      data_mark <= 8'h00;
      hunt_state <= 1'b1;
      break_abort <= 1'b0;
      sync_n <= 1'b1;
      push <= 1'b0;
      push_data <= {`SFR_ENTRY_W{1'b0}};
      residue_code <= 3'h0;
      crc_error <= 1'b0;
      ext_status_event <= 1'b0;
    end else begin
      push <= 1'b0;
      ext_status_event <= 1'b0;
      if (rxc_rise) begin
        sync_n <= 1'b1;
      end
      if (!rx_on || enter_hunt) begin
        if (!hunt_state) begin
          ext_status_event <= 1'b1;
        end
        hunt_state <= 1'b1;
        in_frame <= 1'b0;
        nbits <= 4'h0;
        data_mark <= 8'h00;
        crc <= preset;
      end else if (rxc_rise) begin
        pat <= next_pat;
        // Mark the new bit; a stuffed zero never reaches the data path.
        data_mark <= {!stuffed, data_mark[7:1]};
        ones <= rx_bit ? ((ones == `SFR_ONES_ABORT) ? ones : ones + 3'h1)
                       : 3'h0;
        if (!rx_bit && break_abort) begin
          break_abort <= 1'b0;
          ext_status_event <= 1'b1;
        end
        if (abort_hit) begin
          if (!break_abort) begin
            ext_status_event <= 1'b1;
          end
          break_abort <= 1'b1;
          hunt_state <= 1'b1;
          in_frame <= 1'b0;
          nbits <= 4'h0;
          data_mark <= 8'h00;
          crc <= preset;
        end else if (flag_hit) begin
          sync_n <= 1'b0;
          if (hunt_state) begin
            ext_status_event <= 1'b1;
          end
          hunt_state <= 1'b0;
          first_char <= 1'b1;
          if (in_frame && !hunt_state) begin
            // Closing flag; leftover bits go out with the status.
            push <= 1'b1;
            push_data <= {res_fin, crc_bad, 1'b1, sh_fin};
            residue_code <= res_fin;
            crc_error <= crc_bad;
          end
          in_frame <= 1'b0;
          nbits <= 4'h0;
          since_flag <= 3'h0;
          // The flag's own bits are not data.
          data_mark <= 8'h00;
          crc <= preset;
        end else if (hunt_state) begin
          crc <= preset;
        end else if (data_mark[0]) begin
          // Data bit: assemble, check, and count residue.
          crc <= crc_fin;
          in_frame <= 1'b1;
          since_flag <= since_flag + 3'h1;
          if (nbits + 4'h1 == want) begin
            push <= 1'b1;
            push_data <= {3'h0, 1'b0, 1'b0, sh_fin};
            nbits <= 4'h0;
            first_char <= 1'b0;
          end else begin
            nbits <= nbits + 4'h1;
          end
          shreg <= sh_fin;
        end
      end
    end
  end
  // The CRC and character run eight bits behind the flag detector, so a
  // flag's own bits never reach the character or the checker.

  // ***********************************************
  // Receive FIFO
  // ***********************************************
  sfr_fifo #(
    .WIDTH(`SFR_ENTRY_W),
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(push_ready),
    .in_data(push_data),
    .out_valid(pop_valid),
    .out_ready(rd_data && !locked),
    .out_data(pop_data)
  );

  assign rx_avail = pop_valid && !locked;

  // ***********************************************
  // Output position and special condition
  // ***********************************************
  // Presents the head entry; end-of-frame locks in some modes.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_data <= 8'h00;
      end_of_frame <= 1'b0;
      special_condition <= 1'b0;
      locked <= 1'b0;
      address_byte <= 1'b0;
    end else begin
      rx_data <= pop_data[7:0];
      end_of_frame <= pop_valid && pop_data[`SFR_E_EOF];
      address_byte <= first_char;
      if (pop_valid && pop_data[`SFR_E_EOF]) begin
        special_condition <= 1'b1;
      end else if (error_reset) begin
        special_condition <= 1'b0;
      end
      if (rd_data && pop_valid && pop_data[`SFR_E_EOF] &&
          (rx_int_mode == `SFR_RXI_FIRST ||
           rx_int_mode == `SFR_RXI_SPECIAL)) begin
        locked <= 1'b1;
      end else if (error_reset) begin
        locked <= 1'b0;
      end
    end
  end

  // ***********************************************
  // Modem pins
  // ***********************************************
  // Carrier status follows the pin; ready pin is the inverted bit, or dma_req when dma_req_mode is set.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      carrier_detect_bit <= 1'b0;
      terminal_ready_n <= 1'b1;
    end else begin
      carrier_detect_bit <= sync_b[2];
      terminal_ready_n <= dma_req_mode ? dma_req
                                       : !terminal_ready_bit;
    end
  end
endmodule
`default_nettype wire

// File: tb/sfr_receiver_bench.sv
// Bench for the frame receiver: frames, abort, lock and pin checks.
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map.vh"
module sfr_receiver_bench;
  logic clk, nrst, carrier_detect_pin, rx_enable, auto_enable, enter_hunt;
  logic crc_preset_ones, error_reset, terminal_ready_bit, dma_req_mode;
  logic dma_req, rd_data, e, c, s;
  logic [1:0] char_len, rx_int_mode;
  logic [7:0] flag_pattern_reg, d;
  logic [2:0] r;
  wire rx_clk_pin, rx_data_pin, rx_avail, end_of_frame, crc_error;
  wire special_condition, hunt_state, break_abort, carrier_detect_bit;
  wire ext_status_event, address_byte, sync_n, terminal_ready_n;
  wire [7:0] rx_data;
  wire [2:0] residue_code;
  int miscompares, cmp_count, i;
  sfr_receiver #(.DEPTH(16), .AW(4)) dut (.*);
  sfr_station stn (.rx_clk_pin(rx_clk_pin), .rx_data_pin(rx_data_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string what, input logic [15:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test;
    $display("mismatches %0d, comparisons %0d", miscompares, cmp_count);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Waits for the head entry, samples it, then pops it.
  task automatic pop;
    for (i = 0; i < 200 && rx_avail !== 1'b1; i++) tick(1);
    if (rx_avail !== 1'b1) begin
      check("rx_avail", 0, 1);
      stop_test;
    end
    tick(2);
    d = rx_data;
    e = end_of_frame;
    c = crc_error;
    r = residue_code;
    s = special_condition;
    rd_data = 1'b1;
    tick(1);
    rd_data = 1'b0;
    tick(2);
  endtask
  task automatic hunt;
    enter_hunt = 1'b1;
    tick(1);
    enter_hunt = 1'b0;
  endtask
  // One frame from hunt, read back, then the lock is released.
  task automatic frame(input logic [15:0] bad);
    hunt;
    stn.send_frame(8'hA5, 8'hFF, bad);
    tick(12);
    pop;
    check("address", d, 8'hA5);
    check("special", s, 0);
    pop;
    check("data", d, 8'hFF);
    for (int k = 0; k < 4 && e !== 1'b1; k++) pop;
    check("end_of_frame", e, 1);
    check("crc_error", c, bad != 0);
    check("residue", r, 3'h0);
    check("special", s, 1);
    tick(4);
    check("locked", special_condition, 1);
    error_reset = 1'b1;
    tick(1);
    error_reset = 1'b0;
    tick(2);
    check("unlocked", special_condition, 0);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    carrier_detect_pin = 1'b1;
    rx_enable = 1'b0;
    auto_enable = 1'b1;
    enter_hunt = 1'b0;
    crc_preset_ones = 1'b0;
    error_reset = 1'b0;
    terminal_ready_bit = 1'b0;
    dma_req_mode = 1'b0;
    dma_req = 1'b0;
    rd_data = 1'b0;
    char_len = `SFR_LEN8;
    rx_int_mode = `SFR_RXI_SPECIAL;
    flag_pattern_reg = 8'h7E;
    miscompares = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk);
    #1 nrst = 1'b1;
    tick(4);
    check("hunt_state", hunt_state, 1);
    check("sync_n", sync_n, 1);
    check("break_abort", break_abort, 0);
    check("rx_avail", rx_avail, 0);
    check("carrier_detect_bit", carrier_detect_bit, 1);
    rx_enable = 1'b1;
    stn.send_flag;
    tick(12);
    check("hunt_state", hunt_state, 1);
    carrier_detect_pin = 1'b0;
    tick(4);
    stn.send_flag;
    tick(12);
    check("hunt_state", hunt_state, 0);
    check("carrier_detect_bit", carrier_detect_bit, 0);
    for (int k = 0; k < 2; k++) begin
      terminal_ready_bit = k[0];
      tick(2);
      check("terminal_ready_n", terminal_ready_n, !k[0]);
    end
    frame(16'h0000);
    frame(16'h0001);
    hunt;
    stn.send_flag;
    stn.send_data(8'h12, 1'b0);
    stn.send_data(8'h34, 1'b0);
    stn.send_bit(1'b0);
    stn.send_bit(1'b1);
    stn.send_abort;
    tick(12);
    check("break_abort", break_abort, 1);
    check("hunt_state", hunt_state, 1);
    stn.send_bit(1'b0);
    tick(12);
    check("break_abort", break_abort, 0);
    check("hunt_state", hunt_state, 1);
    pop;
    check("aborted eof", e, 0);
    check("aborted data", d, 8'h12);
    check("aborted rest", rx_avail, 0);
    stn.send_flag;
    tick(12);
    check("hunt_state", hunt_state, 0);
    check("address_byte", address_byte, 1);
    stop_test;
  end
endmodule
`default_nettype wire

// File: tb/sfr_receiver_properties.sv
// Concurrent checks on the frame receiver's ports.
`timescale 1ns/10ps
`default_nettype none
module sfr_receiver_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rx_clk_pin,
  input wire logic terminal_ready_bit,
  input wire logic dma_req_mode,
  input wire logic [1:0] rx_int_mode,
  input wire logic error_reset,
  input wire logic special_condition,
  input wire logic hunt_state,
  input wire logic break_abort,
  input wire logic ext_status_event,
  input wire logic sync_n,
  input wire logic terminal_ready_n
);
  // ****************************************
  // Checks, all on the system clock.
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // The flag marker stays low for at least four system cycles.
  sequence s_sync_back;
    !sync_n [*4];
  endsequence
  // The marker returns high once the next link clock rise is synchronised.
  sequence s_sync_end;
    ##[3:4] sync_n;
  endsequence
  // A flag leaves hunt with the marker low around it.
  sequence s_sync_seen;
    ##[0:2] !sync_n;
  endsequence
  AST_SYNC_PULSE: assert property ($fell(sync_n) |-> s_sync_back)
    else $error("sync marker has the wrong length");
  AST_SYNC_END: assert property (!sync_n && $rose(rx_clk_pin) |-> s_sync_end)
    else $error("sync marker outlasts one link clock");
  AST_HUNT_EVENT: assert property ($changed(hunt_state) |-> ##[0:1] ext_status_event)
    else $error("hunt change without status event");
  AST_ABORT_EVENT: assert property ($changed(break_abort) |-> ##[0:1] ext_status_event)
    else $error("abort change without status event");
  AST_ABORT_HUNT: assert property ($rose(break_abort) |-> ##[0:2] hunt_state)
    else $error("abort did not force hunt");
  AST_ABORT_END_HUNT: assert property ($fell(break_abort) |-> hunt_state)
    else $error("hunt left before a full flag");
  AST_HUNT_EXIT: assert property ($fell(hunt_state) |-> s_sync_seen)
    else $error("hunt left without a flag");
  AST_READY_PIN: assert property (!dma_req_mode ##1 !dma_req_mode |-> terminal_ready_n == !$past(terminal_ready_bit))
    else $error("ready pin is not the inverse of the ready bit");
  AST_FIFO_LOCK: assert property (rx_int_mode[0] && special_condition && !error_reset |=> special_condition)
    else $error("special condition left without error reset");
endmodule
bind sfr_receiver sfr_receiver_properties chk (.*);
`default_nettype wire

// File: tb/sfr_station.sv
// Remote station model that sends flags, stuffed bytes, FCS and aborts.
`timescale 1ns/10ps
`default_nettype none
`include "sfr_map.vh"
module sfr_station (
  output var logic rx_clk_pin,
  output var logic rx_data_pin
);
  logic [15:0] crc; // Running frame check value.
  int ones; // Ones sent since the last zero.
  // The link clock idles low; it only runs while bits are sent.
  initial begin
    rx_clk_pin = 1'b0;
    rx_data_pin = 1'b1;
    ones = 0;
  end
  // Data changes early in the low phase, 80 ns before the rise.
  task automatic send_bit(input logic b);
    #40 rx_data_pin = b;
    #80 rx_clk_pin = 1'b1;
    #40 rx_clk_pin = 1'b0;
    ones = b ? ones + 1 : 0;
  endtask
  // A byte LSB first, a zero inserted after five ones.
  task automatic send_data(input logic [7:0] v, input logic upd);
    for (int k = 0; k < 8; k++) begin
      if (upd) crc = (crc >> 1) ^ ((crc[0] ^ v[k]) ? `SFR_CRC_POLY : 16'h0000);
      send_bit(v[k]);
      if (ones == 5) send_bit(1'b0);
    end
  endtask
  // A flag restarts the check value at the preset of zero.
  task automatic send_flag;
    for (int k = 0; k < 8; k++) send_bit(k != 0 && k != 7);
    ones = 0;
    crc = `SFR_PRESET_ZERO;
  endtask
  // Seven ones, never stuffed.
  task automatic send_abort;
    repeat (7) send_bit(1'b1);
  endtask
  // A whole frame; bad flips bits of the inverted check value.
  task automatic send_frame(input logic [7:0] a, b, input logic [15:0] bad);
    logic [15:0] fcs;
    send_flag;
    send_data(a, 1'b1);
    send_data(b, 1'b1);
    fcs = ~crc ^ bad;
    send_data(fcs[7:0], 1'b0);
    send_data(fcs[15:8], 1'b0);
    send_flag;
  endtask
endmodule
`default_nettype wire
